/* asio_pkg.sv */
package asio_pkg;

  // ********************************
  // Register map and field layout
  // ********************************
  localparam int ASIO_AW = 3;
  localparam logic [2:0] ASIO_OFS_PIN_LEVEL = 3'h0;
  localparam logic [2:0] ASIO_OFS_OUT_LATCH = 3'h1;
  localparam logic [2:0] ASIO_OFS_PIN_DIR = 3'h2;
  localparam logic [2:0] ASIO_OFS_ANA_CFG = 3'h3;
  localparam logic [2:0] ASIO_OFS_CMP_CTL = 3'h4;
  localparam logic [2:0] ASIO_OFS_VREF_CTL = 3'h5;

  localparam logic [7:0] ASIO_PORT_MASK = 8'hfe;
  localparam logic [7:0] ASIO_ANA_CFG_MASK = 8'h3f;
  localparam logic [7:0] ASIO_CMP_WR_MASK = 8'h3f;
  localparam logic [7:0] ASIO_CMP_IN_PINS = 8'h78;

  localparam logic [7:0] ASIO_LAT_RST = 8'h00;
  localparam logic [7:0] ASIO_DIR_RST = 8'hfe;
  localparam logic [7:0] ASIO_ANA_CFG_RST = 8'h00;
  localparam logic [7:0] ASIO_CMP_RST = 8'h00;
  localparam logic [7:0] ASIO_VREF_RST = 8'h00;
  localparam logic [7:0] ASIO_ANALOG_RST = 8'hfe;
  localparam logic [7:0] ASIO_OE_N_RST = 8'hff;

  localparam logic [2:0] ASIO_CMP_MODE_OFF = 3'h7;
  localparam logic [2:0] ASIO_CMP_MODE_OUTS = 3'h3;
  localparam logic [3:0] ASIO_ALL_DIGITAL = 4'hf;

  localparam int ASIO_CMP2_RES_BIT = 7;
  localparam int ASIO_CMP1_RES_BIT = 6;
  localparam int ASIO_CMP2_INV_BIT = 5;
  localparam int ASIO_CMP1_INV_BIT = 4;
  localparam int ASIO_VREF_EN_BIT = 7;
  localparam int ASIO_VREF_OE_BIT = 6;
  localparam int ASIO_VREF_PIN = 5;
  localparam int ASIO_SS_PIN = 7;
  localparam int ASIO_CMP2_OUT_PIN = 1;
  localparam int ASIO_CMP1_OUT_PIN = 2;

  // Converter channel carried by each port pin
  function automatic logic [3:0] asio_chan_of_pin(input int unsigned pin);
    logic [3:0] ch;
    ch = 4'h0;
    unique case (pin)
      7: ch = 4'h5;
      1, 2, 3, 4, 5, 6: ch = 4'(pin + 5);
      default: ch = 4'h0;
    endcase
    return ch;
  endfunction

  // A larger select value turns more channels digital
  function automatic logic [7:0] asio_analog_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = 8'h00;
    for (int p = 1; p < 8; p++) begin
      m[p] = asio_chan_of_pin(p) < (ASIO_ALL_DIGITAL - sel);
    end
    return m;
  endfunction

endpackage

/* asio_ctrl_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface asio_ctrl_if;
  logic [7:0] lat;
  logic [7:0] dir;
  logic [7:0] ana_cfg;
  logic [7:0] cmp_ctl;
  logic [7:0] vref_ctl;
  logic cmp1_raw;
  logic cmp2_raw;
  logic [7:0] pin_in;
  logic [7:0] analog;
  logic cmp_on;
  logic cmp_outs;
  logic vref_pin;
  logic cmp1_res;
  logic cmp2_res;
  logic [7:0] pin_level;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic ss_n;
  modport top (output lat, dir, ana_cfg, cmp_ctl, vref_ctl, cmp1_raw,
    cmp2_raw, pin_in, input analog, cmp_on, cmp_outs, vref_pin, cmp1_res,
    cmp2_res, pin_level, pin_out, pin_oe_n, ss_n);
  modport cfg (input ana_cfg, cmp_ctl, vref_ctl, cmp1_raw, cmp2_raw,
    output analog, cmp_on, cmp_outs, vref_pin, cmp1_res, cmp2_res);
  modport mux (input lat, dir, pin_in, analog, cmp_on, cmp_outs, vref_pin,
    cmp1_res, cmp2_res, output pin_level, pin_out, pin_oe_n, ss_n);
endinterface
`default_nettype wire

/* asio_cfg_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module asio_cfg_decode (
  asio_ctrl_if.cfg c
);

  // ********************************
  // Configuration decode
  // ********************************
  always_comb begin
    c.analog = asio_pkg::asio_analog_mask(c.ana_cfg[3:0]);
    c.cmp_on = c.cmp_ctl[2:0] != asio_pkg::ASIO_CMP_MODE_OFF;
    c.cmp_outs = c.cmp_ctl[2:0] == asio_pkg::ASIO_CMP_MODE_OUTS;
    c.vref_pin = c.vref_ctl[asio_pkg::ASIO_VREF_EN_BIT] &
      c.vref_ctl[asio_pkg::ASIO_VREF_OE_BIT];
    // Results read as zero while the comparators are off
    c.cmp1_res = c.cmp_on &
      (c.cmp1_raw ^ c.cmp_ctl[asio_pkg::ASIO_CMP1_INV_BIT]);
    c.cmp2_res = c.cmp_on &
      (c.cmp2_raw ^ c.cmp_ctl[asio_pkg::ASIO_CMP2_INV_BIT]);
  end

endmodule
`default_nettype wire

/* asio_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module asio_pin_mux (
  asio_ctrl_if.mux m
);

  // ********************************
  // Per-pin steering
  // ********************************
  always_comb begin
    logic in_en;
    logic vref_here;
    in_en = 1'b0;
    vref_here = 1'b0;
    m.pin_level = 8'h00;
    m.pin_out = 8'h00;
    m.pin_oe_n = 8'hff;
    for (int p = 1; p < 8; p++) begin
      vref_here = m.vref_pin && (p == asio_pkg::ASIO_VREF_PIN);
      in_en = !m.analog[p] && !vref_here &&
        !(m.cmp_on && asio_pkg::ASIO_CMP_IN_PINS[p]);
      m.pin_level[p] = in_en & m.pin_in[p];
      m.pin_oe_n[p] = m.dir[p] | vref_here;
      if (m.cmp_outs && p == asio_pkg::ASIO_CMP2_OUT_PIN) begin
        m.pin_out[p] = m.cmp2_res;
      end else if (m.cmp_outs && p == asio_pkg::ASIO_CMP1_OUT_PIN) begin
        m.pin_out[p] = m.cmp1_res;
      end else begin
        // Analog selection never gates the output driver
        m.pin_out[p] = m.lat[p] & !vref_here;
      end
    end
    // Slave select idles inactive unless pin 7 is a digital input
    m.ss_n = (m.dir[asio_pkg::ASIO_SS_PIN] &&
      !m.analog[asio_pkg::ASIO_SS_PIN]) ?
      m.pin_in[asio_pkg::ASIO_SS_PIN] : 1'b1;
  end

endmodule
`default_nettype wire

/* asio_port.sv */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Seven pins 1..7, bit 0 absent
// - Direction bit per pin, 0 output
// - Output latch drives pin despite analog
// - Input reads pin, analog disables input
// - Reset makes pins 6..1 analog, read zero
// - Pins 1..6 serve comparator functions
// - 07h stops comparators, 0Fh all digital
// - Comparator outputs override latch on 1,2
// - Reference output on pin 5 isolates it
// - Pins 1,2,7 map channels 6,7,5
// - Pins 3..6 channels 8..11, comparator inputs
// - Pin 7 input feeds slave select
// - Unimplemented bits ignore writes, read zero
module asio_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic [asio_pkg::ASIO_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  output logic [7:0] analog_pin_mask,
  output logic comparators_on,
  output logic reference_voltage_output,
  output logic [7:0] vref_settings,
  output logic slave_select_n
);

  // ********************************
  // Registers
  // ********************************
  logic [7:0] lat_ff;
  logic [7:0] dir_ff;
  logic [7:0] ana_cfg_ff;
  logic [7:0] cmp_ctl_ff;
  logic [7:0] vref_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] pin_out_ff;
  logic [7:0] pin_oe_n_ff;
  logic [7:0] analog_ff;
  logic cmp_on_ff;
  logic vref_pin_ff;
  logic ss_n_ff;
  logic wr_lat;

  asio_ctrl_if cif ();

  assign cif.lat = lat_ff;
  assign cif.dir = dir_ff;
  assign cif.ana_cfg = ana_cfg_ff;
  assign cif.cmp_ctl = cmp_ctl_ff;
  assign cif.vref_ctl = vref_ff;
  assign cif.cmp1_raw = cmp1_raw;
  assign cif.cmp2_raw = cmp2_raw;
  assign cif.pin_in = pin_in;

  asio_cfg_decode u_cfg (
    .c(cif.cfg)
  );

  asio_pin_mux u_mux (
    .m(cif.mux)
  );

  // Writing either data register lands in the latch
  assign wr_lat = reg_wr && (reg_addr == asio_pkg::ASIO_OFS_PIN_LEVEL ||
    reg_addr == asio_pkg::ASIO_OFS_OUT_LATCH);

  always_ff @(posedge clk) begin
    if (reset) begin
      lat_ff <= asio_pkg::ASIO_LAT_RST;
    end else if (wr_lat) begin
      lat_ff <= reg_wdata & asio_pkg::ASIO_PORT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dir_ff <= asio_pkg::ASIO_DIR_RST;
    end else if (reg_wr && reg_addr == asio_pkg::ASIO_OFS_PIN_DIR) begin
      dir_ff <= reg_wdata & asio_pkg::ASIO_PORT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ana_cfg_ff <= asio_pkg::ASIO_ANA_CFG_RST;
    end else if (reg_wr && reg_addr == asio_pkg::ASIO_OFS_ANA_CFG) begin
      ana_cfg_ff <= reg_wdata & asio_pkg::ASIO_ANA_CFG_MASK;
    end
  end

  // Result bits are live status, so writes there are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_ctl_ff <= asio_pkg::ASIO_CMP_RST;
    end else if (reg_wr && reg_addr == asio_pkg::ASIO_OFS_CMP_CTL) begin
      cmp_ctl_ff <= reg_wdata & asio_pkg::ASIO_CMP_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vref_ff <= asio_pkg::ASIO_VREF_RST;
    end else if (reg_wr && reg_addr == asio_pkg::ASIO_OFS_VREF_CTL) begin
      vref_ff <= reg_wdata;
    end
  end

  // ********************************
  // Read path
  // ********************************
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      asio_pkg::ASIO_OFS_PIN_LEVEL: nxt_rdata = cif.pin_level;
      asio_pkg::ASIO_OFS_OUT_LATCH: nxt_rdata = lat_ff;
      asio_pkg::ASIO_OFS_PIN_DIR: nxt_rdata = dir_ff;
      asio_pkg::ASIO_OFS_ANA_CFG: nxt_rdata = ana_cfg_ff;
      asio_pkg::ASIO_OFS_CMP_CTL: begin
        nxt_rdata = cmp_ctl_ff;
        nxt_rdata[asio_pkg::ASIO_CMP2_RES_BIT] = cif.cmp2_res;
        nxt_rdata[asio_pkg::ASIO_CMP1_RES_BIT] = cif.cmp1_res;
      end
      asio_pkg::ASIO_OFS_VREF_CTL: nxt_rdata = vref_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ********************************
  // Pin and status outputs
  // ********************************
  // One flop stage on the pins keeps them glitch free
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out_ff <= 8'h00;
      pin_oe_n_ff <= asio_pkg::ASIO_OE_N_RST;
      ss_n_ff <= 1'b1;
    end else begin
      pin_out_ff <= cif.pin_out;
      pin_oe_n_ff <= cif.pin_oe_n;
      ss_n_ff <= cif.ss_n;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      analog_ff <= asio_pkg::ASIO_ANALOG_RST;
      cmp_on_ff <= 1'b0;
      vref_pin_ff <= 1'b0;
    end else begin
      analog_ff <= cif.analog;
      cmp_on_ff <= cif.cmp_on;
      vref_pin_ff <= cif.vref_pin;
    end
  end

  assign reg_rdata = rdata_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;
  assign analog_pin_mask = analog_ff;
  assign comparators_on = cmp_on_ff;
  assign reference_voltage_output = vref_pin_ff;
  assign vref_settings = vref_ff;
  assign slave_select_n = ss_n_ff;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_rd_level;
    reg_rd && reg_addr == asio_pkg::ASIO_OFS_PIN_LEVEL;
  endsequence

  sequence s_wr_latch;
    reg_wr && reg_addr == asio_pkg::ASIO_OFS_OUT_LATCH;
  endsequence

  sequence s_rd_latch;
    reg_rd && reg_addr == asio_pkg::ASIO_OFS_OUT_LATCH;
  endsequence

  a_bit0_absent: assert property (
    reg_rd && reg_addr <= asio_pkg::ASIO_OFS_PIN_DIR |=>
      !reg_rdata[0] && pin_oe_n[0])
    else $error("bit 0 not absent");

  a_oe_follows_dir: assert property (
    !vref_ff[asio_pkg::ASIO_VREF_EN_BIT] |=>
      pin_oe_n[7:1] == $past(dir_ff[7:1]) || $past(reset))
    else $error("pin enable does not follow direction");

  a_latch_on_pins: assert property (
    pin_out[7:6] == $past(lat_ff[7:6]) &&
      pin_out[4:3] == $past(lat_ff[4:3]) || $past(reset))
    else $error("latch value not on pins");

  a_analog_reads_zero: assert property (
    s_rd_level ##1 1 |-> (reg_rdata & $past(cif.analog)) == 8'h00)
    else $error("analog pin read as nonzero");

  a_reset_analog: assert property (
    $past(reset) |-> ana_cfg_ff == asio_pkg::ASIO_ANA_CFG_RST &&
      cif.analog[6:1] == 6'h3f)
    else $error("reset not analog");

  a_cmp_inputs_off: assert property (
    cif.cmp_on and s_rd_level |=> reg_rdata[6:3] == 4'h0)
    else $error("comparator input read as digital");

  a_cmp_off_write: assert property (
    reg_wr && reg_addr == asio_pkg::ASIO_OFS_CMP_CTL &&
      reg_wdata == 8'h07 |=> ##1 !comparators_on)
    else $error("comparators not off");

  a_all_digital: assert property (
    reg_wr && reg_addr == asio_pkg::ASIO_OFS_ANA_CFG &&
      reg_wdata == 8'h0f |=> ##1 analog_pin_mask == 8'h00)
    else $error("port not digital");

  a_cmp_override: assert property (
    cif.cmp_outs && !dir_ff[1] && !dir_ff[2] |=>
      pin_out[1] == $past(cif.cmp2_res) && !pin_oe_n[1] &&
      pin_out[2] == $past(cif.cmp1_res))
    else $error("comparator output not on pin");

  a_vref_isolate: assert property (
    cif.vref_pin |=> pin_oe_n[5] && reference_voltage_output)
    else $error("reference pin not isolated");

  a_chan_map: assert property (
    ana_cfg_ff[3:0] < 4'ha |=> analog_pin_mask[7])
    else $error("pin 7 channel not analog");

  a_slave_select: assert property (
    dir_ff[7] && !cif.analog[7] |=> slave_select_n == $past(pin_in[7]))
    else $error("slave select not from pin 7");

  a_latch_readback: assert property (
    s_wr_latch ##1 s_rd_latch |=>
      reg_rdata == ($past(reg_wdata, 2) & asio_pkg::ASIO_PORT_MASK))
    else $error("latch readback wrong");

  sequence s_rd_cmp;
    reg_rd && reg_addr == asio_pkg::ASIO_OFS_CMP_CTL;
  endsequence

  sequence s_wr_cmp;
    reg_wr && reg_addr == asio_pkg::ASIO_OFS_CMP_CTL;
  endsequence

  // Offsets above the last register decode to nothing
  a_unmapped_read: assert property (
    reg_rd && reg_addr > asio_pkg::ASIO_OFS_VREF_CTL |=>
      reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  a_unmapped_write: assert property (
    reg_wr && reg_addr > asio_pkg::ASIO_OFS_VREF_CTL |=>
      $stable(lat_ff) && $stable(dir_ff) && $stable(ana_cfg_ff) &&
      $stable(cmp_ctl_ff) && $stable(vref_ff))
    else $error("unmapped write changed a register");

  a_ana_cfg_top: assert property (
    reg_rd && reg_addr == asio_pkg::ASIO_OFS_ANA_CFG |=>
      reg_rdata[7:6] == 2'h0)
    else $error("analog config top bits nonzero");

  a_latch_write: assert property (
    reg_wr && reg_addr <= asio_pkg::ASIO_OFS_OUT_LATCH |=>
      lat_ff == ($past(reg_wdata) & asio_pkg::ASIO_PORT_MASK))
    else $error("latch write lost");

  a_dir_write: assert property (
    reg_wr && reg_addr == asio_pkg::ASIO_OFS_PIN_DIR |=>
      dir_ff == ($past(reg_wdata) & asio_pkg::ASIO_PORT_MASK))
    else $error("direction write lost");

  a_cmp_ctl_write: assert property (
    s_wr_cmp |=>
      cmp_ctl_ff == ($past(reg_wdata) & asio_pkg::ASIO_CMP_WR_MASK))
    else $error("comparator control write lost");

  a_cmp_res_off: assert property (
    s_rd_cmp ##0 !cif.cmp_on |=> reg_rdata[7:6] == 2'h0)
    else $error("comparator result while off");

  // Pins 1, 2 and 5 lose the latch only to an alternate function
  a_latch_alt_pins: assert property (
    !cif.cmp_outs && !cif.vref_pin |=>
      pin_out[5] == $past(lat_ff[5]) &&
      pin_out[2:1] == $past(lat_ff[2:1]))
    else $error("latch value missing on shared pin");

  a_read_pin7: assert property (
    s_rd_level |=>
      reg_rdata[7] == ($past(pin_in[7]) && !$past(cif.analog[7])))
    else $error("pin 7 read wrong");

  a_read_pins12: assert property (
    s_rd_level |=>
      reg_rdata[2:1] == ($past(pin_in[2:1]) & ~$past(cif.analog[2:1])))
    else $error("pins 1 and 2 read wrong");

  a_vref_no_input: assert property (
    cif.vref_pin and s_rd_level |=> !reg_rdata[5])
    else $error("reference pin read as digital");

  a_chan_pins12: assert property (
    analog_pin_mask[2:1] == {$past(ana_cfg_ff[3:0]) < 4'h8,
      $past(ana_cfg_ff[3:0]) < 4'h9} || $past(reset))
    else $error("pins 1 and 2 channel map wrong");

  // Comparator inputs sit on the highest channels, dropped first
  a_chan_pins36: assert property (
    analog_pin_mask[6:3] == {$past(ana_cfg_ff[3:0]) < 4'h4,
      $past(ana_cfg_ff[3:0]) < 4'h5, $past(ana_cfg_ff[3:0]) < 4'h6,
      $past(ana_cfg_ff[3:0]) < 4'h7} || $past(reset))
    else $error("pins 3 to 6 channel map wrong");

  a_ss_idle: assert property (
    !dir_ff[asio_pkg::ASIO_SS_PIN] |=> slave_select_n)
    else $error("slave select active on output pin");

  a_reset_pins: assert property (
    $past(reset) |-> analog_pin_mask[6:1] == 6'h3f &&
      pin_oe_n == asio_pkg::ASIO_OE_N_RST)
    else $error("pins not analog inputs after reset");

endmodule
`default_nettype wire

/* asio_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Board side of the port pins
// ****************************
module asio_board_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // Board yields to the device wherever the device drives, no contention
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pin_in[p] = pin_oe_n[p] ? ext_level[p] : pin_out[p];
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************
  // Stimulus and design
  // ****************************
  logic clk, reset, reg_wr, reg_rd, cmp1_raw, cmp2_raw;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, ext_level;
  logic [7:0] analog_pin_mask, vref_settings;
  logic comparators_on, reference_voltage_output, slave_select_n;
  int n_errors, comparisons, cycles;
  logic [7:0] rb;
  int m_lat, m_dir, m_ana, m_cmp, m_vref;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  asio_port dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw),
    .analog_pin_mask(analog_pin_mask), .comparators_on(comparators_on),
    .reference_voltage_output(reference_voltage_output),
    .vref_settings(vref_settings), .slave_select_n(slave_select_n));
  asio_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));

  // ****************************
  // Reference model
  // ****************************
  function automatic logic [7:0] m_analog();
    logic [7:0] m;
    int ch [8] = '{0, 6, 7, 8, 9, 10, 11, 5};
    m = 8'h00;
    for (int p = 1; p < 8; p++) m[p] = ch[p] < 15 - (m_ana & 15);
    return m;
  endfunction
  function automatic logic m_on();
    return m_cmp[2:0] != 3'h7;
  endfunction
  function automatic logic m_vp();
    return m_vref[7] & m_vref[6];
  endfunction
  function automatic logic [7:0] m_oe();
    logic [7:0] o;
    o = m_dir[7:0] | 8'h01;
    o[5] = o[5] | m_vp();
    return o;
  endfunction
  function automatic logic [7:0] m_out();
    logic [7:0] o;
    o = m_lat[7:0] & 8'hfe;
    if (m_cmp[2:0] == 3'h3) begin
      o[1] = cmp2_raw ^ m_cmp[5];
      o[2] = cmp1_raw ^ m_cmp[4];
    end
    return o;
  endfunction
  function automatic logic [7:0] m_read(int a);
    logic [7:0] w, en;
    w = (m_oe() & ext_level) | (~m_oe() & m_out());
    en = ~m_analog() & 8'hfe;
    if (m_on()) en = en & 8'h87;
    if (m_vp()) en[5] = 1'b0;
    case (a)
      0: return w & en;
      1: return m_lat[7:0];
      2: return m_dir[7:0];
      3: return m_ana[7:0];
      4: return {m_on() & (cmp2_raw ^ m_cmp[5]),
        m_on() & (cmp1_raw ^ m_cmp[4]), m_cmp[5:0]};
      5: return m_vref[7:0];
      default: return 8'h00;
    endcase
  endfunction

  // ****************************
  // Bus tasks and checks
  // ****************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      0, 1: m_lat = d & 8'hfe;
      2: m_dir = d & 8'hfe;
      3: m_ana = d & 8'h3f;
      4: m_cmp = d & 8'h3f;
      5: m_vref = d;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Latch write then read with no gap between the strobes
  task automatic wr_rd(input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= asio_pkg::ASIO_OFS_OUT_LATCH;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    m_lat = d & 8'hfe;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk_all(input string name);
    logic [7:0] oe, an, v;
    repeat (3) @(posedge clk);
    #1;
    oe = m_oe();
    an = m_analog();
    check(pin_oe_n, oe);
    check(pin_out & ~oe, m_out() & ~oe);
    check(analog_pin_mask, an);
    check(comparators_on, m_on());
    check(reference_voltage_output, m_vp());
    check(vref_settings, m_vref[7:0]);
    check(slave_select_n, !(m_dir[7] && !an[7]) || ext_level[7]);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), v);
      check(v, m_read(a));
    end
    @(posedge clk);
    #1 check(reg_rdata, 8'h00);
    $display("test %s done", name);
  endtask
  task automatic stop_test();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Sweep needs about 512 cycles, the whole run about 640, so this leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    ext_level = 8'h00;
    cmp1_raw = 1'b0;
    cmp2_raw = 1'b0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    m_lat = 0;
    m_dir = 8'hfe;
    m_ana = 0;
    m_cmp = 0;
    m_vref = 0;
    void'($urandom(32'hce8aad70));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    chk_all("reset");
    wr(asio_pkg::ASIO_OFS_OUT_LATCH, 8'hab);
    wr(asio_pkg::ASIO_OFS_PIN_DIR, 8'h00);
    ext_level <= 8'h55;
    chk_all("latch_drive");
    wr(asio_pkg::ASIO_OFS_CMP_CTL, 8'h07);
    wr(asio_pkg::ASIO_OFS_ANA_CFG, 8'h0f);
    wr(asio_pkg::ASIO_OFS_PIN_DIR, 8'hce);
    ext_level <= 8'($urandom);
    chk_all("digital");
    wr(asio_pkg::ASIO_OFS_CMP_CTL, 8'h23);
    wr(asio_pkg::ASIO_OFS_PIN_DIR, 8'h00);
    cmp1_raw <= 1'b1;
    cmp2_raw <= 1'b1;
    wr_rd(8'h5b, rb);
    check(rb, 8'h5a);
    chk_all("cmp_outputs");
    // Every analog select once and every comparator mode twice
    for (int i = 0; i < 16; i++) begin
      wr(3'($urandom), 8'($urandom));
      wr(asio_pkg::ASIO_OFS_PIN_LEVEL, 8'($urandom));
      wr(asio_pkg::ASIO_OFS_PIN_DIR, 8'($urandom));
      wr(asio_pkg::ASIO_OFS_ANA_CFG, 8'($urandom) & 8'hf0 | 8'(i));
      wr(asio_pkg::ASIO_OFS_CMP_CTL, 8'($urandom) & 8'hf8 | 8'(i % 8));
      wr(asio_pkg::ASIO_OFS_VREF_CTL, 8'($urandom));
      ext_level <= 8'($urandom);
      cmp1_raw <= 1'($urandom);
      cmp2_raw <= 1'($urandom);
      chk_all("mode_sweep");
    end
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    m_lat = 0;
    m_dir = 8'hfe;
    m_ana = 0;
    m_cmp = 0;
    m_vref = 0;
    chk_all("second_reset");
    stop_test();
  end
endmodule
`default_nettype wire
